// >>> rtl/level_gauge_regs.vh
// constants for the level gauge alarm/status register block
// assumes a single 50 MHz clock and a register port fed by a Modbus slave front end
//
// Summary of operation
// - results are averaged over a window: code 0 gives 1 s, codes 5..60 in steps of 5 give that many seconds
// - status bits D1..D8: interface, product, roof, average temperature high/low alarms
// - D9 missing magnet, D10..D14 sensor 0..4 errors, D15 average temperature error
// - status bit is 1 when active, 0 when not; D16..D32 always read 0
// - correction factor error register holds 0 on success, else code 1..9
// - volume error register holds 0 on success, else code 1..4
// - undefined or reserved register reads give 8000H, or 80000000H over a pair
// - reads at register 35198 or above get exception code 02 instead of data
// - temperature unit code: 0 Celsius, 1 Fahrenheit
// - density unit codes run 0..8
// - volume unit codes run 0..6
// - length unit codes run 0..6
// - mass unit codes run 0..5
// - new device address accepts only 1..247; other values are refused and the old address stays
// - alarm unit type 2 volume or 3 length; roof alarms are length only
// - high alarm is active when the quantity is greater than or equal its threshold
// - low alarm is active when the quantity is less than or equal its threshold
// - high/low pairs are read high word first and joined as unsigned 32 bits
// - every register reads by function 03 or 04; all are read only
`ifndef LEVEL_GAUGE_REGS_VH
`define LEVEL_GAUGE_REGS_VH

// timing
`define CLK_PERIOD_NS      20
`define AVG_SECOND_NS      1000000000
`define AVG_SECOND_CYCLES  (`AVG_SECOND_NS / `CLK_PERIOD_NS)

// data addresses (register number minus 30001)
`define ADDR_TEMP_UNIT_HI  16'd299
`define ADDR_TEMP_UNIT_LO  16'd300
`define ADDR_DENS_UNIT_HI  16'd301
`define ADDR_DENS_UNIT_LO  16'd302
`define ADDR_VOL_UNIT_HI   16'd303
`define ADDR_VOL_UNIT_LO   16'd304
`define ADDR_LEN_UNIT_HI   16'd305
`define ADDR_LEN_UNIT_LO   16'd306
`define ADDR_MASS_UNIT_HI  16'd307
`define ADDR_MASS_UNIT_LO  16'd308
`define ADDR_NEW_DEV_ADDR  16'd309
`define ADDR_ALARM_UNIT_HI 16'd1108
`define ADDR_ALARM_UNIT_LO 16'd1109
`define ADDR_THR_FIRST     16'd1110
`define ADDR_THR_LAST      16'd1125
`define ADDR_STATUS_HI     16'd1126
`define ADDR_STATUS_LO     16'd1127
`define ADDR_VCF_ERR       16'd1128
`define ADDR_VOL_ERR       16'd1129
`define ADDR_AVG_INTERVAL  16'd1130
`define ADDR_MAP_END       16'd5197

// reply values
`define WORD_RESERVED      16'h8000
`define WORD_ZERO          16'h0000
`define FUNC_READ_HOLD     8'h03
`define FUNC_READ_INPUT    8'h04
`define EXC_ILLEGAL_FUNC   8'h01
`define EXC_ILLEGAL_VALUE  8'h02

// field limits and reset values
`define TEMP_UNIT_MAX      8'h01
`define DENS_UNIT_MAX      8'h08
`define VOL_UNIT_MAX       8'h06
`define LEN_UNIT_MAX       8'h06
`define MASS_UNIT_MAX      8'h05
`define DEV_ADDR_MIN       8'h01
`define DEV_ADDR_MAX       8'hF7
`define DEV_ADDR_RESET     8'h01
`define ALARM_UNIT_VOLUME  8'h02
`define ALARM_UNIT_LENGTH  8'h03
`define INTERVAL_STEP      8'h05
`define INTERVAL_MAX       8'h3C
`define VCF_ERR_MAX        8'h09
`define VOL_ERR_MAX        8'h04

// status word bit positions (D1 is bit 0)
`define ST_MAGNET_MISSING  8
`define ST_DTS_ERR_LSB     9
`define ST_AVG_TEMP_ERR    14
`define ST_USED_BITS       15

`endif

// >>> rtl/level_gauge_alarm_status_regs.v
// alarm/status word, error code registers and configuration registers of the gauge
// assumes measurements arrive as strobed unsigned samples and reads arrive as one-cycle
// requests already decoded from a Modbus frame
`include "level_gauge_regs.vh"

module level_gauge_alarm_status_regs #(
    parameter [31:0] SECOND_CYCLES = `AVG_SECOND_CYCLES
) (
    input  wire        clk,
    input  wire        arst_n,
    // register read port
    input  wire        rd_req,
    input  wire [7:0]  rd_func,
    input  wire [15:0] rd_addr,
    output reg         rd_ack,
    output reg  [15:0] rd_data,
    output reg         rd_exc,
    output reg  [7:0]  rd_exc_code,
    // configuration from the local menu
    input  wire        cfg_stb,
    input  wire [7:0]  cfg_interval,
    input  wire [7:0]  cfg_temp_unit,
    input  wire [7:0]  cfg_dens_unit,
    input  wire [7:0]  cfg_vol_unit,
    input  wire [7:0]  cfg_len_unit,
    input  wire [7:0]  cfg_mass_unit,
    input  wire [7:0]  cfg_dev_addr,
    input  wire [7:0]  cfg_alarm_unit,
    input  wire [31:0] cfg_iface_high,
    input  wire [31:0] cfg_iface_low,
    input  wire [31:0] cfg_prod_high,
    input  wire [31:0] cfg_prod_low,
    input  wire [31:0] cfg_roof_high,
    input  wire [31:0] cfg_roof_low,
    input  wire [31:0] cfg_temp_high,
    input  wire [31:0] cfg_temp_low,
    // measurements and faults
    input  wire        meas_stb,
    input  wire [31:0] iface_level,
    input  wire [31:0] iface_volume,
    input  wire [31:0] prod_level,
    input  wire [31:0] prod_volume,
    input  wire [31:0] roof_level,
    input  wire [31:0] avg_temp,
    input  wire        magnet_missing,
    input  wire [4:0]  dts_err,
    input  wire        avg_temp_err,
    input  wire [7:0]  vcf_err_code,
    input  wire [7:0]  vol_err_code,
    // state seen by the rest of the device
    output reg  [31:0] status_word,
    output reg  [7:0]  dev_addr,
    output reg         eval_pulse
);

    // word of a high/low pair
    function [15:0] pair_word;
        input [31:0] val;
        input        low_half;
        begin
            pair_word = low_half ? val[15:0] : val[31:16];
        end
    endfunction

    // code lies in 0..max
    function code_ok;
        input [7:0] code;
        input [7:0] max;
        begin
            code_ok = (code <= max);
        end
    endfunction

    // interval code: 0 or a multiple of 5 up to 60
    function interval_ok;
        input [7:0] code;
        begin
            interval_ok = (code == 8'h00) ||
                          ((code <= `INTERVAL_MAX) && ((code % `INTERVAL_STEP) == 8'h00));
        end
    endfunction

    reg  [7:0]  interval_reg;
    reg  [7:0]  temp_unit_reg;
    reg  [7:0]  dens_unit_reg;
    reg  [7:0]  vol_unit_reg;
    reg  [7:0]  len_unit_reg;
    reg  [7:0]  mass_unit_reg;
    reg  [7:0]  alarm_unit_reg;
    reg  [7:0]  vcf_err_reg;
    reg  [7:0]  vol_err_reg;
    reg  [31:0] thr_reg [0:7];
    reg  [47:0] sum_reg [0:3];
    reg  [15:0] cnt_reg;
    reg  [31:0] tick_reg;
    reg  [7:0]  sec_left_reg;
    reg  [15:0] last_addr_reg;
    reg         last_rsv_reg;
    reg  [31:0] quant [0:3];
    reg  [14:0] status_next;
    reg  [47:0] limit;
    reg  [15:0] word_next;
    reg         rsv_next;
    reg  [15:0] thr_idx;
    integer     i, j, k;

    wire        second_end = (tick_reg == SECOND_CYCLES - 32'd1);
    wire        window_end = second_end && (sec_left_reg == 8'h00);
    wire        vol_alarms = (alarm_unit_reg == `ALARM_UNIT_VOLUME);

    // window length in seconds minus one; code 0 means one second
    wire [7:0]  window_secs = (interval_reg == 8'h00) ? 8'h00 : interval_reg - 8'h01;

    // configuration: invalid codes are refused and the old value stays
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            interval_reg   <= 8'h00;
            temp_unit_reg  <= 8'h00;
            dens_unit_reg  <= 8'h00;
            vol_unit_reg   <= 8'h00;
            len_unit_reg   <= 8'h00;
            mass_unit_reg  <= 8'h00;
            dev_addr       <= `DEV_ADDR_RESET;
            alarm_unit_reg <= `ALARM_UNIT_LENGTH;
            for (i = 0; i < 8; i = i + 1)
                thr_reg[i] <= (i % 2 == 0) ? 32'hFFFFFFFF : 32'h00000000;
        end
        else if (cfg_stb)
        begin
            if (interval_ok(cfg_interval))
                interval_reg <= cfg_interval;
            if (code_ok(cfg_temp_unit, `TEMP_UNIT_MAX))
                temp_unit_reg <= cfg_temp_unit;
            if (code_ok(cfg_dens_unit, `DENS_UNIT_MAX))
                dens_unit_reg <= cfg_dens_unit;
            if (code_ok(cfg_vol_unit, `VOL_UNIT_MAX))
                vol_unit_reg <= cfg_vol_unit;
            if (code_ok(cfg_len_unit, `LEN_UNIT_MAX))
                len_unit_reg <= cfg_len_unit;
            if (code_ok(cfg_mass_unit, `MASS_UNIT_MAX))
                mass_unit_reg <= cfg_mass_unit;
            if (cfg_dev_addr >= `DEV_ADDR_MIN && cfg_dev_addr <= `DEV_ADDR_MAX)
                dev_addr <= cfg_dev_addr;
            if (cfg_alarm_unit == `ALARM_UNIT_VOLUME || cfg_alarm_unit == `ALARM_UNIT_LENGTH)
                alarm_unit_reg <= cfg_alarm_unit;
            thr_reg[0] <= cfg_iface_high;
            thr_reg[1] <= cfg_iface_low;
            thr_reg[2] <= cfg_prod_high;
            thr_reg[3] <= cfg_prod_low;
            thr_reg[4] <= cfg_roof_high;
            thr_reg[5] <= cfg_roof_low;
            thr_reg[6] <= cfg_temp_high;
            thr_reg[7] <= cfg_temp_low;
        end
    end

    // quantity under watch; interface and product follow the alarm unit type,
    // roof is always a length since its thresholds can only be lengths
    always @*
    begin
        quant[0] = vol_alarms ? iface_volume : iface_level;
        quant[1] = vol_alarms ? prod_volume : prod_level;
        quant[2] = roof_level;
        quant[3] = avg_temp;
    end

    // one-second tick and seconds left in the window
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tick_reg     <= 32'h00000000;
            sec_left_reg <= 8'h00;
        end
        else if (second_end)
        begin
            tick_reg     <= 32'h00000000;
            sec_left_reg <= (sec_left_reg == 8'h00) ? window_secs : sec_left_reg - 8'h01;
        end
        else
        begin
            tick_reg <= tick_reg + 32'h00000001;
        end
    end

    // sample accumulation; a sample on the closing edge opens the next window
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_reg <= 16'h0000;
            for (j = 0; j < 4; j = j + 1)
                sum_reg[j] <= 48'h000000000000;
        end
        else if (window_end)
        begin
            cnt_reg <= meas_stb ? 16'h0001 : 16'h0000;
            for (j = 0; j < 4; j = j + 1)
                sum_reg[j] <= meas_stb ? {16'h0000, quant[j]} : 48'h000000000000;
        end
        else if (meas_stb && cnt_reg != 16'hFFFF)
        begin
            cnt_reg <= cnt_reg + 16'h0001;
            for (j = 0; j < 4; j = j + 1)
                sum_reg[j] <= sum_reg[j] + {16'h0000, quant[j]};
        end
    end

    // threshold test on the mean without a divider: mean >= t  <=>  sum >= t * n;
    // the product costs multipliers but keeps the check in a single cycle
    always @*
    begin
        status_next = 15'h0000;
        limit = 48'h000000000000;
        for (k = 0; k < 4; k = k + 1)
        begin
            limit = thr_reg[2 * k] * cnt_reg;
            status_next[2 * k] = (sum_reg[k] >= limit);
            limit = thr_reg[2 * k + 1] * cnt_reg;
            status_next[2 * k + 1] = (sum_reg[k] <= limit);
        end
        status_next[`ST_MAGNET_MISSING] = magnet_missing;
        status_next[`ST_DTS_ERR_LSB + 4:`ST_DTS_ERR_LSB] = dts_err;
        status_next[`ST_AVG_TEMP_ERR] = avg_temp_err;
    end

    // status word refreshed at each window end; a window with no samples
    // keeps the old alarms, faults are taken every window
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_word <= 32'h00000000;
            eval_pulse  <= 1'b0;
        end
        else
        begin
            eval_pulse <= window_end;
            if (window_end)
            begin
                status_word[31:`ST_USED_BITS] <= 17'h00000;
                status_word[`ST_USED_BITS - 1:8] <= status_next[14:8];
                if (cnt_reg != 16'h0000)
                    status_word[7:0] <= status_next[7:0];
            end
        end
    end

    // error codes follow the calculations; codes outside the defined set are dropped
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vcf_err_reg <= 8'h00;
            vol_err_reg <= 8'h00;
        end
        else
        begin
            if (code_ok(vcf_err_code, `VCF_ERR_MAX))
                vcf_err_reg <= vcf_err_code;
            if (code_ok(vol_err_code, `VOL_ERR_MAX))
                vol_err_reg <= vol_err_code;
        end
    end

    // read decode; everything not named below is reserved space
    always @*
    begin
        word_next = `WORD_RESERVED;
        rsv_next  = 1'b0;
        thr_idx   = 16'h0000;
        case (rd_addr)
            `ADDR_TEMP_UNIT_HI,
            `ADDR_DENS_UNIT_HI,
            `ADDR_VOL_UNIT_HI,
            `ADDR_LEN_UNIT_HI,
            `ADDR_MASS_UNIT_HI,
            `ADDR_ALARM_UNIT_HI: word_next = `WORD_ZERO;
            `ADDR_TEMP_UNIT_LO:  word_next = {8'h00, temp_unit_reg};
            `ADDR_DENS_UNIT_LO:  word_next = {8'h00, dens_unit_reg};
            `ADDR_VOL_UNIT_LO:   word_next = {8'h00, vol_unit_reg};
            `ADDR_LEN_UNIT_LO:   word_next = {8'h00, len_unit_reg};
            `ADDR_MASS_UNIT_LO:  word_next = {8'h00, mass_unit_reg};
            `ADDR_NEW_DEV_ADDR:  word_next = {8'h00, dev_addr};
            `ADDR_ALARM_UNIT_LO: word_next = {8'h00, alarm_unit_reg};
            `ADDR_STATUS_HI:     word_next = pair_word(status_word, 1'b0);
            `ADDR_STATUS_LO:     word_next = pair_word(status_word, 1'b1);
            `ADDR_VCF_ERR:       word_next = {8'h00, vcf_err_reg};
            `ADDR_VOL_ERR:       word_next = {8'h00, vol_err_reg};
            `ADDR_AVG_INTERVAL:  word_next = {8'h00, interval_reg};
            default:
            begin
                if (rd_addr >= `ADDR_THR_FIRST && rd_addr <= `ADDR_THR_LAST)
                begin
                    thr_idx   = rd_addr - `ADDR_THR_FIRST;
                    word_next = pair_word(thr_reg[thr_idx[3:1]], thr_idx[0]);
                end
                else
                begin
                    // second word of a reserved pair completes 80000000H
                    rsv_next  = 1'b1;
                    word_next = (last_rsv_reg && rd_addr == last_addr_reg + 16'h0001) ?
                                `WORD_ZERO : `WORD_RESERVED;
                end
            end
        endcase
    end

    // answer one cycle after the request; only reads are served, nothing is writable
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_ack        <= 1'b0;
            rd_data       <= 16'h0000;
            rd_exc        <= 1'b0;
            rd_exc_code   <= 8'h00;
            last_addr_reg <= 16'h0000;
            last_rsv_reg  <= 1'b0;
        end
        else
        begin
            rd_ack <= rd_req;
            if (rd_req)
            begin
                if (rd_func != `FUNC_READ_HOLD && rd_func != `FUNC_READ_INPUT)
                begin
                    rd_exc       <= 1'b1;
                    rd_exc_code  <= `EXC_ILLEGAL_FUNC;
                    rd_data      <= 16'h0000;
                    last_rsv_reg <= 1'b0;
                end
                else if (rd_addr >= `ADDR_MAP_END)
                begin
                    rd_exc       <= 1'b1;
                    rd_exc_code  <= `EXC_ILLEGAL_VALUE;
                    rd_data      <= 16'h0000;
                    last_rsv_reg <= 1'b0;
                end
                else
                begin
                    rd_exc       <= 1'b0;
                    rd_exc_code  <= 8'h00;
                    rd_data      <= word_next;
                    last_rsv_reg <= rsv_next;
                end
                last_addr_reg <= rd_addr;
            end
        end
    end

endmodule // level_gauge_alarm_status_regs

// >>> verification/gauge_properties.sv
// port-level checks for the gauge alarm/status register block
// assumes it is bound to the design top; one clock, async active-low reset
`include "level_gauge_regs.vh"
module gauge_properties #(
    parameter [31:0] SECOND_CYCLES = 4
) (
    input wire        clk,
    input wire        arst_n,
    input wire        rd_req,
    input wire [7:0]  rd_func,
    input wire [15:0] rd_addr,
    input wire        rd_ack,
    input wire [15:0] rd_data,
    input wire        rd_exc,
    input wire [7:0]  rd_exc_code,
    input wire        cfg_stb,
    input wire [7:0]  cfg_dev_addr,
    input wire [31:0] status_word,
    input wire [7:0]  dev_addr,
    input wire        eval_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // request qualifiers; a served read is 03/04 inside the map
    wire        fn_ok  = rd_func == `FUNC_READ_HOLD || rd_func == `FUNC_READ_INPUT;
    wire        rd_ok  = rd_req && fn_ok && rd_addr < `ADDR_MAP_END;
    wire        cfg_ok = cfg_stb && cfg_dev_addr >= `DEV_ADDR_MIN && cfg_dev_addr <= `DEV_ADDR_MAX;
    wire [15:0] st_lo  = status_word[15:0];

    AST_ACK: assert property (rd_ack == $past(rd_req))
        else $error("answer strobe not one cycle after request");
    AST_FN_EXC: assert property (rd_req && !fn_ok |=> rd_exc && rd_exc_code == `EXC_ILLEGAL_FUNC)
        else $error("unserved function not refused");
    AST_MAP_EXC: assert property (rd_req && fn_ok && rd_addr >= `ADDR_MAP_END |=>
        rd_exc && rd_exc_code == `EXC_ILLEGAL_VALUE && rd_data == `WORD_ZERO)
        else $error("read beyond map not refused with code 02");
    AST_IN_MAP: assert property (rd_ok |=> !rd_exc)
        else $error("read inside map refused");
    AST_ST_HI: assert property (rd_ok && rd_addr == `ADDR_STATUS_HI |=> rd_data == `WORD_ZERO)
        else $error("status high word not zero");
    AST_ST_LO: assert property (rd_ok && rd_addr == `ADDR_STATUS_LO |=> rd_data == $past(st_lo))
        else $error("status low word differs from status");
    AST_VCF: assert property (rd_ok && rd_addr == `ADDR_VCF_ERR |=> rd_data <= 16'h0009)
        else $error("correction error code out of range");
    AST_RSVD_BITS: assert property (status_word[31:15] == 17'h00000)
        else $error("reserved status bits set");
    AST_ADDR_LOAD: assert property (cfg_ok |=> dev_addr == $past(cfg_dev_addr))
        else $error("valid device address not taken");
    AST_ADDR_KEEP: assert property (cfg_stb && !cfg_ok |=> $stable(dev_addr))
        else $error("invalid device address taken");
    AST_EVAL: assert property (eval_pulse |=> !eval_pulse)
        else $error("evaluation pulse longer than one cycle");
    AST_ST_EVAL: assert property ($changed(status_word) |-> eval_pulse)
        else $error("status changed outside an evaluation");

    COV_EXC: cover property (rd_ack && rd_exc);
    COV_RSVD: cover property (rd_ack && rd_data == `WORD_RESERVED);
    COV_ALARM: cover property (eval_pulse && status_word[7:0] != 8'h00);
endmodule // gauge_properties

bind level_gauge_alarm_status_regs gauge_properties #(.SECOND_CYCLES(SECOND_CYCLES)) i_gauge_properties (
    .clk(clk), .arst_n(arst_n), .rd_req(rd_req), .rd_func(rd_func), .rd_addr(rd_addr),
    .rd_ack(rd_ack), .rd_data(rd_data), .rd_exc(rd_exc), .rd_exc_code(rd_exc_code),
    .cfg_stb(cfg_stb), .cfg_dev_addr(cfg_dev_addr), .status_word(status_word),
    .dev_addr(dev_addr), .eval_pulse(eval_pulse)
);

// >>> verification/modbus_master_model.sv
// stand-in Modbus master polling the register read port
// assumes a request is taken on one edge and answered on the next
module modbus_master_model (
    input  wire         clk,
    output logic        rd_req,
    output logic [7:0]  rd_func,
    output logic [15:0] rd_addr,
    input  wire         rd_ack,
    input  wire  [15:0] rd_data,
    input  wire         rd_exc,
    input  wire  [7:0]  rd_exc_code
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        rd_req  = 1'b0;
        rd_func = 8'h00;
        rd_addr = 16'h0000;
    end
    // n words back to back; idle bus shows inverted values so stale data cannot match
    task automatic read_words(input logic [7:0] f, input logic [15:0] a, input int n,
        output logic [31:0] d, output logic ex, output logic [7:0] code, output logic ok);
        d  = 32'h00000000;
        ok = 1'b1;
        @(posedge clk);
        rd_req  <= 1'b1;
        rd_func <= f;
        rd_addr <= a;
        for (int i = 0; i <= n; i++)
        begin
            @(posedge clk);
            if (i > 0)
            begin
                ok = ok & rd_ack;
                d  = {d[15:0], rd_data};
            end
            if (i == n - 1)
            begin
                rd_req  <= 1'b0;
                rd_func <= ~f;
                rd_addr <= ~a;
            end
            else if (i < n - 1)
                rd_addr <= a + 16'(i + 1);
        end
        ex   = rd_exc;
        code = rd_exc_code;
    endtask
endmodule // modbus_master_model

// >>> verification/level_gauge_alarm_status_regs_tb.sv
// self-checking bench for the gauge alarm/status register block
// assumes the design header is on the include path; seconds shortened to 4 cycles
`include "level_gauge_regs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module level_gauge_alarm_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SEC = 4;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        cfg_stb = 1'b0;
    logic        meas_stb = 1'b0;
    logic        magnet_missing = 1'b0;
    logic        avg_temp_err = 1'b0;
    logic [4:0]  dts_err = 5'h00;
    logic [7:0]  vcf_err_code = 8'h00;
    logic [7:0]  vol_err_code = 8'h00;
    logic [7:0]  cfg_v [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03};
    logic [31:0] thr [0:7] = '{default: 32'h00000000};
    logic [31:0] q [0:5] = '{default: 32'h00000000};
    wire         rd_req, rd_ack, rd_exc, eval_pulse;
    wire  [7:0]  rd_func, rd_exc_code, dev_addr;
    wire  [15:0] rd_addr, rd_data;
    wire  [31:0] status_word;
    logic [31:0] d;
    logic        ex, ok;
    logic [7:0]  code;
    int          mdl [0:9] = '{0, 0, 0, 0, 0, 0, 1, 3, 0, 0}; // config 0..7, error codes 8..9
    int          failures = 0;
    int          checks = 0;

    level_gauge_alarm_status_regs #(.SECOND_CYCLES(SEC)) i_level_gauge_alarm_status_regs (
        .clk(clk), .arst_n(arst_n), .rd_req(rd_req), .rd_func(rd_func), .rd_addr(rd_addr),
        .rd_ack(rd_ack), .rd_data(rd_data), .rd_exc(rd_exc), .rd_exc_code(rd_exc_code),
        .cfg_stb(cfg_stb), .cfg_interval(cfg_v[0]), .cfg_temp_unit(cfg_v[1]),
        .cfg_dens_unit(cfg_v[2]), .cfg_vol_unit(cfg_v[3]), .cfg_len_unit(cfg_v[4]),
        .cfg_mass_unit(cfg_v[5]), .cfg_dev_addr(cfg_v[6]), .cfg_alarm_unit(cfg_v[7]),
        .cfg_iface_high(thr[0]), .cfg_iface_low(thr[1]), .cfg_prod_high(thr[2]),
        .cfg_prod_low(thr[3]), .cfg_roof_high(thr[4]), .cfg_roof_low(thr[5]),
        .cfg_temp_high(thr[6]), .cfg_temp_low(thr[7]), .meas_stb(meas_stb),
        .iface_level(q[0]), .iface_volume(q[1]), .prod_level(q[2]), .prod_volume(q[3]),
        .roof_level(q[4]), .avg_temp(q[5]), .magnet_missing(magnet_missing),
        .dts_err(dts_err), .avg_temp_err(avg_temp_err), .vcf_err_code(vcf_err_code),
        .vol_err_code(vol_err_code), .status_word(status_word), .dev_addr(dev_addr),
        .eval_pulse(eval_pulse));
    modbus_master_model i_modbus_master_model (
        .clk(clk), .rd_req(rd_req), .rd_func(rd_func), .rd_addr(rd_addr), .rd_ack(rd_ack),
        .rd_data(rd_data), .rd_exc(rd_exc), .rd_exc_code(rd_exc_code));
    always #10 clk = ~clk;
    // field acceptance as the model sees it
    function automatic bit valid_cfg(int k, int v);
        case (k)
            0: return v == 0 || (v % 5 == 0 && v <= 60);
            1: return v <= 1;
            2: return v <= 8;
            3, 4: return v <= 6;
            5: return v <= 5;
            6: return v >= 1 && v <= 247;
            default: return v == 2 || v == 3;
        endcase
    endfunction
    // thresholds are fed in the same units as the quantities compared
    function automatic logic [31:0] exp_status();
        logic [31:0] s;
        logic [31:0] qq [0:3];
        s = 32'h00000000;
        qq[0] = (mdl[7] == 2) ? q[1] : q[0];
        qq[1] = (mdl[7] == 2) ? q[3] : q[2];
        qq[2] = q[4];
        qq[3] = q[5];
        for (int k = 0; k < 4; k++)
        begin
            s[2 * k] = qq[k] >= thr[2 * k];
            s[2 * k + 1] = qq[k] <= thr[2 * k + 1];
        end
        s[14:8] = {avg_temp_err, dts_err, magnet_missing};
        return s;
    endfunction
    task automatic rd(input logic [7:0] f, input logic [15:0] a, input int n);
        i_modbus_master_model.read_words(f, a, n, d, ex, code, ok);
        `CHK(ok, 1'b1)
    endtask
    // strobe all fields, then let the loading edge settle
    task automatic apply_cfg();
        @(posedge clk);
        cfg_stb <= 1'b1;
        @(posedge clk);
        cfg_stb <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 8; k++)
            if (valid_cfg(k, cfg_v[k]))
                mdl[k] = cfg_v[k];
    endtask
    task automatic wait_eval();
        int n;
        @(posedge clk);
        for (n = 0; n < 100 && eval_pulse !== 1'b1; n++)
            @(posedge clk);
        `CHK(eval_pulse, 1'b1)
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (10000) @(posedge clk);
        failures++;
        end_of_test();
    end

    initial
    begin
        void'($urandom(29071));
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        // reset state, reserved places and refused reads
        rd(`FUNC_READ_HOLD, `ADDR_STATUS_HI, 2);
        `CHK(d, 32'h00000000)
        `CHK(dev_addr, `DEV_ADDR_RESET)
        rd(`FUNC_READ_INPUT, 16'd500, 2);
        `CHK(d, 32'h80000000)
        rd(`FUNC_READ_HOLD, 16'd5196, 1);
        `CHK({ex, d[15:0]}, {1'b0, `WORD_RESERVED})
        for (int i = 0; i < 2; i++)
        begin
            rd(`FUNC_READ_HOLD, i ? 16'($urandom_range(5198, 65535)) : `ADDR_MAP_END, 1);
            `CHK({ex, code, d[15:0]}, {1'b1, `EXC_ILLEGAL_VALUE, `WORD_ZERO})
        end
        rd(8'h06, `ADDR_STATUS_HI, 1);
        `CHK({ex, code}, {1'b1, `EXC_ILLEGAL_FUNC})
        $display("test reads done");
        // error code registers, out-of-range codes keep the old value
        for (int i = 0; i < 12; i++)
        begin
            vcf_err_code <= 8'($urandom_range(0, 12));
            vol_err_code <= 8'($urandom_range(0, 6));
            @(posedge clk);
            if (vcf_err_code <= `VCF_ERR_MAX)
                mdl[8] = vcf_err_code;
            if (vol_err_code <= `VOL_ERR_MAX)
                mdl[9] = vol_err_code;
            rd(`FUNC_READ_HOLD, `ADDR_VCF_ERR, 2);
            `CHK(d, {16'(mdl[8]), 16'(mdl[9])})
        end
        $display("test error codes done");
        // small values make equality with thresholds frequent
        meas_stb <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            cfg_v[7] <= 8'(2 + i % 3);
            for (int k = 0; k < 8; k++)
                thr[k] <= $urandom_range(0, 3);
            for (int k = 0; k < 6; k++)
                q[k] <= $urandom_range(0, 3);
            {magnet_missing, avg_temp_err, dts_err} <= 7'($urandom);
            apply_cfg();
            wait_eval();
            wait_eval();
            `CHK(status_word, exp_status())
            rd(`FUNC_READ_INPUT, `ADDR_STATUS_HI, 2);
            `CHK(d, exp_status())
            rd(`FUNC_READ_HOLD, `ADDR_ALARM_UNIT_HI, 2);
            `CHK(d, mdl[7])
            rd(`FUNC_READ_HOLD, `ADDR_THR_FIRST + 16'(2 * (i % 8)), 2);
            `CHK(d, thr[i % 8])
        end
        meas_stb <= 1'b0;
        $display("test alarms done");
        // codes 0..63 of every unit field and the interval; device address 0..2, 246..248 and random values
        for (int v = 0; v < 64; v++)
        begin
            for (int k = 0; k < 6; k++)
                cfg_v[k] <= 8'(v);
            cfg_v[6] <= (v < 3) ? 8'(v) : (v > 60) ? 8'(185 + v) : 8'($urandom_range(2, 246));
            apply_cfg();
            `CHK(dev_addr, 8'(mdl[6]))
            for (int k = 1; k < 6; k++)
            begin
                rd(`FUNC_READ_HOLD, `ADDR_TEMP_UNIT_HI + 16'(2 * k - 2), 2);
                `CHK(d, mdl[k])
            end
            rd(`FUNC_READ_INPUT, `ADDR_AVG_INTERVAL, 1);
            `CHK(d[7:0], 8'(mdl[0]))
        end
        $display("test configuration done");
        end_of_test();
    end
endmodule // level_gauge_alarm_status_regs_tb
